// *** core/stepper_phase_sequencer.sv ***
// Notes on behaviour
// - The phase state advances one step only on a rising step clock edge, never a falling one.
// - Mode low selects two-phase and high 1-2 phase; direction low is forward, high reverse.
// - While the active-low reset is low the sequencer resets and all four windings are off.
// - After reset release with step clock low, winding one positive and two negative drive.
// - In 1-2 phase mode each winding pair is idle a quarter of the steps, one-pair states.
// - Mode is sampled on each rising step clock edge and applies from that edge onward.
`timescale 1ns/100ps
`default_nettype none

module stepper_phase_sequencer (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // host controls, synchronous to clock
  input  wire logic reset_low_input,
  input  wire logic step_clock,
  input  wire logic mode_select,
  input  wire logic direction_select,
  // winding drives
  output logic      winding_one_pos,
  output logic      winding_one_neg,
  output logic      winding_two_pos,
  output logic      winding_two_neg
);

  typedef struct packed {
    stepper_pkg::seq_state_t state;
    logic                    step_prev;
    stepper_pkg::pos_t       pos;
    stepper_pkg::phase_t     phase;
  } regs_t;

  regs_t               r;
  regs_t               nxt;
  stepper_pkg::phase_t phase_at;
  stepper_pkg::pos_t   pos_nxt;
  stepper_pkg::pos_t   pos_sel;
  logic                rise;

  ////////////////////////////////////////////////////////////////////////////
  // next wheel position for one step
  function automatic stepper_pkg::pos_t advance(input stepper_pkg::pos_t p,
                                                input logic               m,
                                                input logic               d);
    stepper_pkg::pos_t inc;
    stepper_pkg::pos_t base;
    inc  = (m == stepper_pkg::MODE_TWO_PHASE) ? stepper_pkg::POS_FULL_STEP
                                               : stepper_pkg::POS_ONE;
    // two-phase mode snaps back onto an even, two-pair position
    base = (m == stepper_pkg::MODE_TWO_PHASE && p[0]) ? p - stepper_pkg::POS_ONE : p;
    if (d == stepper_pkg::DIR_FORWARD)
      advance = stepper_pkg::pos_t'(base + inc);
    else if (base != p)
      advance = stepper_pkg::pos_t'(base + inc - stepper_pkg::POS_FULL_STEP);
    else
      advance = stepper_pkg::pos_t'(base - inc);
  endfunction : advance

  ////////////////////////////////////////////////////////////////////////////
  assign pos_nxt = advance(r.pos, mode_select, direction_select);
  assign rise    = step_clock && !r.step_prev;

  // position chosen apart from the state copy, so the decoder sees no loop
  always_comb begin
    if (!reset_low_input || r.state != stepper_pkg::SEQ_RUN)
      pos_sel = stepper_pkg::POS_FIRST;
    else if (rise)
      pos_sel = pos_nxt;
    else
      pos_sel = r.pos;
  end

  phase_decode u_decode (
    .pos   (pos_sel),
    .phase (phase_at)
  );

  always_comb begin
    nxt           = r;
    nxt.step_prev = step_clock;
    case (r.state)
      stepper_pkg::SEQ_RESET: begin
        nxt.pos = stepper_pkg::POS_FIRST;
        if (reset_low_input)
          nxt.state = stepper_pkg::SEQ_RUN;
      end
      stepper_pkg::SEQ_RUN: begin
        if (rise) begin
          nxt.pos = pos_sel;
        end
      end
      default: nxt.state = stepper_pkg::SEQ_RESET;
    endcase
    nxt.phase = phase_at;
    if (!reset_low_input) begin
      nxt.state = stepper_pkg::SEQ_RESET;
      nxt.pos   = stepper_pkg::POS_FIRST;
      nxt.phase = stepper_pkg::PHASE_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r.state     <= stepper_pkg::SEQ_RESET;
      r.step_prev <= 1'b1;
      r.pos       <= stepper_pkg::POS_FIRST;
      r.phase     <= stepper_pkg::PHASE_OFF;
    end else begin
      r <= nxt;
    end
  end

  assign winding_one_pos = r.phase[3];
  assign winding_one_neg = r.phase[2];
  assign winding_two_pos = r.phase[1];
  assign winding_two_neg = r.phase[0];

endmodule : stepper_phase_sequencer

`default_nettype wire

// *** core/stepper_pkg.sv ***
package stepper_pkg;

  // phase position on the eight-entry half-step wheel
  localparam int unsigned POS_W = 3;
  typedef logic [POS_W-1:0] pos_t;

  // the first excitation state: winding one positive with winding two negative
  localparam pos_t POS_FIRST     = 3'h0;
  // one position on the wheel
  localparam pos_t POS_ONE       = 3'h1;
  // a whole step in two-phase mode spans two wheel positions
  localparam pos_t POS_FULL_STEP = 3'h2;

  // winding bits: {one_pos, one_neg, two_pos, two_neg}
  typedef logic [3:0] phase_t;
  localparam phase_t PHASE_OFF = 4'h0;

  // mode and direction input levels
  localparam logic MODE_TWO_PHASE = 1'b0;
  localparam logic DIR_FORWARD    = 1'b0;

  // minimum reset hold and clock level width, in ns, and as clock cycles
  localparam int unsigned CLOCK_NS        = 5;
  localparam int unsigned RESET_HOLD_NS   = 20000;
  localparam int unsigned RESET_HOLD_CYC  = (RESET_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int unsigned STEP_LEVEL_NS   = 20000;
  localparam int unsigned STEP_LEVEL_CYC  = (STEP_LEVEL_NS + CLOCK_NS - 1) / CLOCK_NS;

  typedef enum logic [1:0] {
    SEQ_RESET,
    SEQ_RUN
  } seq_state_t;

endpackage : stepper_pkg

// *** core/phase_decode.sv ***
`timescale 1ns/100ps
`default_nettype none

module phase_decode (
  // wheel position
  input  wire stepper_pkg::pos_t   pos,
  // winding pattern
  output var  stepper_pkg::phase_t phase
);

  ////////////////////////////////////////////////////////////////////////////
  // half-step wheel; odd positions energise one winding pair only
  always_comb begin
    case (pos)
      3'h0:    phase = 4'b1001;
      3'h1:    phase = 4'b1000;
      3'h2:    phase = 4'b1010;
      3'h3:    phase = 4'b0010;
      3'h4:    phase = 4'b0110;
      3'h5:    phase = 4'b0100;
      3'h6:    phase = 4'b0101;
      3'h7:    phase = 4'b0001;
      default: phase = stepper_pkg::PHASE_OFF;
    endcase
  end

endmodule : phase_decode

`default_nettype wire

// *** dv/phase_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module phase_monitor (
  // watched pins
  input wire logic clock, rst_b, reset_low_input, step_clock, mode_select,
  input wire logic winding_one_pos, winding_one_neg, winding_two_pos, winding_two_neg
);
  wire logic [3:0] w = {winding_one_pos, winding_one_neg, winding_two_pos, winding_two_neg};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_run; reset_low_input && $past(reset_low_input, 4); endsequence
  sequence s_step; $rose(step_clock) ##0 s_run; endsequence
  property p_off; !reset_low_input |=> w == 4'h0; endproperty
  a_off: assert property (p_off) else $error("on in reset");
  property p_first; $rose(reset_low_input) |-> ##[1:3] w == 4'h9; endproperty
  a_first: assert property (p_first) else $error("no first state");
  property p_cause;
    $changed(w) ##0 s_run |-> $past(step_clock) && !$past(step_clock, 2)
      || $past(step_clock, 2) && !$past(step_clock, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("change without rise");
  property p_move; s_step |=> ##[0:1] $changed(w); endproperty
  a_move: assert property (p_move) else $error("rise missed");
  property p_two; s_step ##0 !mode_select ##2 reset_low_input |-> $countones(w) == 2; endproperty
  a_two: assert property (p_two) else $error("bad full step");
  property p_half;
    s_step ##0 mode_select ##2 reset_low_input |-> $countones(w) != $countones($past(w, 2));
  endproperty
  a_half: assert property (p_half) else $error("bad half step");
  property p_excl; w[3:2] != 2'h3 && w[1:0] != 2'h3; endproperty
  a_excl: assert property (p_excl) else $error("both ends on");
endmodule : phase_monitor
bind stepper_phase_sequencer phase_monitor mon (.*);
`default_nettype wire

// *** dv/step_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module step_host #(parameter int LVL = 8) (
  input  wire logic clock,
  output logic      reset_low_input, step_clock, mode_select, direction_select
);
  initial {reset_low_input, step_clock, mode_select, direction_select} = 4'h0;
  task automatic hold_reset(input int n);
    @(negedge clock) reset_low_input = 1'b0;
    repeat (n) @(negedge clock);
    reset_low_input = 1'b1;
    repeat (4) @(negedge clock);
  endtask : hold_reset
  task automatic step(input logic m, d);
    @(negedge clock) {mode_select, direction_select, step_clock} = {m, d, 1'b1};
    repeat (LVL) @(negedge clock);
    step_clock = 1'b0;
    repeat (LVL) @(negedge clock);
  endtask : step
endmodule : step_host
`default_nettype wire

// *** dv/tb_stepper_phase_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_stepper_phase_sequencer;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  wire logic rli, stc, ms, ds;
  wire logic [3:0] w;
  logic [3:0] ws = 4'h0, q[$];
  logic [2:0] p;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  localparam logic [3:0] WHEEL [8] = '{4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
  always #2.5 clock = ~clock;
  step_host host (.clock(clock), .reset_low_input(rli), .step_clock(stc), .mode_select(ms),
    .direction_select(ds));
  stepper_phase_sequencer dut (.clock(clock), .rst_b(rst_b), .reset_low_input(rli),
    .step_clock(stc), .mode_select(ms), .direction_select(ds), .winding_one_pos(w[3]),
    .winding_one_neg(w[2]), .winding_two_pos(w[1]), .winding_two_neg(w[0]));
  task automatic check(input logic [3:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] windings exp %h seen %h", exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic go(input int n);
    if (rli) q.push_back(4'h0);
    q.push_back(4'h9);
    p = 3'h0;
    host.hold_reset(n);
  endtask : go
  task automatic step(input logic m, d);
    p = d ? p - ((m | p[0]) ? 3'h1 : 3'h2) : p + ((m | p[0]) ? 3'h1 : 3'h2);
    q.push_back(WHEEL[p]);
    host.step(m, d);
  endtask : step
  // outputs looked at half a period after the edge that launches them
  always @(negedge clock) begin
    cyc++;
    if (cyc > 8000) begin
      n_mismatch++;
      report_and_stop();
    end else if (rst_b) begin
      if (w !== ws && q.size() == 0) check(w, ws);
      else if (w !== ws) check(w, q.pop_front());
      ws = w;
    end
  end
  initial begin
    void'($urandom(79));
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    go(4000);
    for (int i = 0; i < 48; i++) begin
      if (i == 24) go(8);
      step(i < 4 ? i[1] : 1'($urandom), i < 4 ? i[0] : 1'($urandom));
    end
    repeat (4) @(negedge clock);
    check(4'(q.size()), 4'h0);
    report_and_stop();
  end
endmodule : tb_stepper_phase_sequencer
`default_nettype wire
